/* uart_map.svh */
`ifndef UART_MAP_SVH
`define UART_MAP_SVH

// register indices; byte address is four times the index
`define IDX_STATUS      16'h4100
`define IDX_TXDATA      16'h4101
`define IDX_RXDATA      16'h4102
`define IDX_MODE        16'h4103
`define IDX_CTRL        16'h4104
`define IDX_BAUD        16'h4106

// reset values
`define STATUS_RESET    8'h01
`define TXDATA_RESET    8'h00
`define RXDATA_RESET    8'h00
`define MODE_RESET      8'h00
`define CTRL_RESET      8'h00
`define BAUD_RESET      8'h00

// status bit positions
`define ST_TX_DONE      7
`define ST_FRAMING      6
`define ST_PARITY       5
`define ST_OVERRUN      4

// writable setup bits, reserved bits read zero
`define MODE_MASK       8'h1e
`define CTRL_MASK       8'hf3

// samples per serial bit
`define OVERSAMPLE_DEF  16

`endif

/* uart_pkg.sv */
package uart_pkg;

  // channel status, bit 7 down to bit 0
  typedef struct packed {
    logic tx_done_flag;
    logic framing_error_flag;
    logic parity_error_flag;
    logic overrun_error_flag;
    logic second_byte_flag;
    logic tx_busy_flag;
    logic rx_ready_flag;
    logic tx_buffer_empty_flag;
  } status_type;

  // character format setup
  typedef struct packed {
    logic [2:0] rsv_hi;
    logic       char_length_select;
    logic       parity_enable;
    logic       parity_odd;
    logic       two_stop_bits;
    logic       rsv_lo;
  } mode_type;

  // transfer control and interrupt enables
  typedef struct packed {
    logic       tx_end_ie;
    logic       rx_error_ie;
    logic       rx_full_ie;
    logic       tx_empty_ie;
    logic [1:0] rsv;
    logic       rx_threshold_select;
    logic       channel_enable;
  } ctrl_type;

  typedef enum logic [4:0] {
    TX_IDLE   = 5'b0_0001,
    TX_START  = 5'b0_0010,
    TX_DATA   = 5'b0_0100,
    TX_PARITY = 5'b0_1000,
    TX_STOP   = 5'b1_0000
  } tx_state_type;

  typedef enum logic [4:0] {
    RX_IDLE   = 5'b0_0001,
    RX_START  = 5'b0_0010,
    RX_DATA   = 5'b0_0100,
    RX_PARITY = 5'b0_1000,
    RX_STOP   = 5'b1_0000
  } rx_state_type;

endpackage

/* uart_data_status_regs.sv */
// Functional notes
// - done flag sets when busy falls; write one clears, zero ignored
// - framing error flag sets when received stop bit is low
// - parity checked only if enabled, at buffer entry; mismatch sets flag
// - overrun flag sets on char completing with buffer full; buffer kept
// - each receive error flag clears only by writing one to it
// - second byte flag sets on second entry, clears on first read
// - busy flag rises on shift register load, falls at transfer end
// - ready flag sets on entry, clears once all entries read
// - buffer empty flag clears on data write, sets on handoff
// - status resets to 0x01; bits 3 to 0 are read only
// - data write starts transmission; value held and readable back
// - buffer empty cause on every handoff
// - seven-bit mode ignores transmit data top bit
// - transmit shifts least significant bit first, one is high level
// - two entry receive buffer, oldest character read first
// - receive full cause when count reaches chosen threshold
// - seven-bit mode puts zero in received top bit
// - first received bit becomes least significant; high is one
// - receive data read only, resets to zero, writes ignored
// - length select one is eight bits, zero seven, reset seven
// - threshold select zero means one character, one means two
// - all causes share one request line
`timescale 1ns/1ps
`include "uart_map.svh"

module uart_data_status_regs
  import uart_pkg::*;
#(
  parameter int OVERSAMPLE = `OVERSAMPLE_DEF
)
(
  input  wire logic        ref_clk_i,        // system clock
  input  wire logic        reset_n_i,        // sync reset, active low
  input  wire logic        hsel_i,           // ahb slave select
  input  wire logic [31:0] haddr_i,          // ahb address
  input  wire logic [1:0]  htrans_i,         // ahb transfer type
  input  wire logic        hwrite_i,         // ahb write
  input  wire logic [2:0]  hsize_i,          // ahb size, word only
  input  wire logic [31:0] hwdata_i,         // ahb write data
  input  wire logic        hready_i,         // ahb bus ready
  output logic             hreadyout_o,      // ahb slave ready
  output logic [31:0]      hrdata_o,         // ahb read data
  output logic             hresp_o,          // ahb response, okay
  input  wire logic        serial_in_pin_i,  // serial line in
  output logic             serial_out_pin_o, // serial line out
  output logic             irq_o             // shared interrupt request
);

  localparam int OSW = $clog2(OVERSAMPLE);
  localparam logic [OSW-1:0] OS_LAST = OSW'(OVERSAMPLE - 1);
  localparam logic [OSW-1:0] OS_MID  = OSW'(OVERSAMPLE / 2 - 1);

  // mid-bit sampling needs a few samples
  generate
    if (OVERSAMPLE < 4 || OVERSAMPLE > 256)
    begin : g_check
      $error("OVERSAMPLE must lie between 4 and 256");
    end
  endgenerate

  // byte address of a register index
  function automatic logic [31:0] word_addr(input logic [15:0] idx);
    word_addr = {14'h0000, idx, 2'b00};
  endfunction

  // even parity bit, or odd when asked
  function automatic logic parity_of(input logic [7:0] d, input logic odd);
    parity_of = (^d) ^ odd;
  endfunction

  // char cut to the selected length
  function automatic logic [7:0] char_mask(input logic [7:0] d, input logic eight);
    char_mask = eight ? d : {1'b0, d[6:0]};
  endfunction

  logic                ap_valid_ff;
  logic                ap_write_ff;
  logic [31:0]         ap_addr_ff;
  logic [31:0]         hrdata_ff;
  logic                hreadyout_ff;
  logic                hresp_ff;
  mode_type            mode_ff;
  ctrl_type            ctrl_ff;
  logic [7:0]          baud_ff;
  logic [7:0]          baud_cnt_ff;
  logic [7:0]          tx_buf_ff;
  logic                tbe_ff;
  logic                busy_ff;
  logic                done_ff;
  logic                framing_ff;
  logic                parity_ff;
  logic                overrun_ff;
  tx_state_type        tx_state_ff;
  logic [7:0]          tx_shift_ff;
  logic [2:0]          tx_bit_ff;
  logic [OSW-1:0]      tx_os_ff;
  logic                tx_par_ff;
  logic                tx_stop_left_ff;
  logic                serial_out_ff;
  logic                sin_meta_ff;
  logic                sin_sync_ff;
  rx_state_type        rx_state_ff;
  logic [7:0]          rx_shift_ff;
  logic [2:0]          rx_bit_ff;
  logic [OSW-1:0]      rx_os_ff;
  logic                rx_par_bit_ff;
  logic [7:0]          fifo_mem_ff [2];
  logic                wr_ptr_ff;
  logic                rd_ptr_ff;
  logic [1:0]          count_ff;
  logic                irq_ff;

  logic                take;
  logic                rd_take;
  logic                wr_en;
  logic                wr_status;
  logic                wr_tx;
  logic [7:0]          wbyte;
  logic                pop;
  logic                en;
  logic                tick;
  logic                load;
  logic                tx_end;
  logic                rx_done;
  logic                push;
  logic                overrun_set;
  logic                framing_set;
  logic                parity_set;
  logic [2:0]          last_bit;
  status_type          status;
  logic [7:0]          rd_byte;

  // bus decode; data phase one cycle later
  assign take      = hsel_i && htrans_i[1] && hready_i;
  assign rd_take   = take && !hwrite_i;
  assign wr_en     = ap_valid_ff && ap_write_ff;
  assign wbyte     = hwdata_i[7:0];
  assign wr_status = wr_en && (ap_addr_ff == word_addr(`IDX_STATUS));
  assign wr_tx     = wr_en && (ap_addr_ff == word_addr(`IDX_TXDATA));
  // an empty buffer is never popped
  assign pop       = rd_take && (haddr_i == word_addr(`IDX_RXDATA)) && (count_ff != 2'd0);

  assign en       = ctrl_ff.channel_enable;
  assign last_bit = mode_ff.char_length_select ? 3'd7 : 3'd6;

  // status view; receive buffer flags follow the fill count
  always_comb
  begin
    status.tx_done_flag         = done_ff;
    status.framing_error_flag   = framing_ff;
    status.parity_error_flag    = parity_ff;
    status.overrun_error_flag   = overrun_ff;
    status.second_byte_flag     = (count_ff == 2'd2);
    status.tx_busy_flag         = busy_ff;
    status.rx_ready_flag        = (count_ff != 2'd0);
    status.tx_buffer_empty_flag = tbe_ff;
  end

  // read mux on the address phase; unmapped reads give zero
  always_comb
  begin
    rd_byte = 8'h00;
    if (haddr_i == word_addr(`IDX_STATUS))
      rd_byte = status;
    else if (haddr_i == word_addr(`IDX_TXDATA))
      rd_byte = tx_buf_ff;
    else if (haddr_i == word_addr(`IDX_RXDATA))
      rd_byte = fifo_mem_ff[rd_ptr_ff];
    else if (haddr_i == word_addr(`IDX_MODE))
      rd_byte = mode_ff;
    else if (haddr_i == word_addr(`IDX_CTRL))
      rd_byte = ctrl_ff;
    else if (haddr_i == word_addr(`IDX_BAUD))
      rd_byte = baud_ff;
  end

  // address phase capture; no wait states
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      ap_valid_ff  <= 1'b0;
      ap_write_ff  <= 1'b0;
      ap_addr_ff   <= 32'h0000_0000;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
    else
    begin
      ap_valid_ff  <= take;
      ap_write_ff  <= hwrite_i;
      ap_addr_ff   <= haddr_i;
      hreadyout_ff <= 1'b1;
      hresp_ff     <= 1'b0;
    end
  end

  // read data stands through the data phase
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      hrdata_ff <= 32'h0000_0000;
    else if (rd_take)
      hrdata_ff <= {24'h00_0000, rd_byte};
  end

  // setup registers; receive data has no write path
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      mode_ff <= `MODE_RESET;
      ctrl_ff <= `CTRL_RESET;
      baud_ff <= `BAUD_RESET;
    end
    else if (wr_en)
    begin
      if (ap_addr_ff == word_addr(`IDX_MODE))
        mode_ff <= wbyte & `MODE_MASK;
      if (ap_addr_ff == word_addr(`IDX_CTRL))
        ctrl_ff <= wbyte & `CTRL_MASK;
      if (ap_addr_ff == word_addr(`IDX_BAUD))
        baud_ff <= wbyte;
    end
  end

  // one tick every baud+1 cycles
  assign tick = en && (baud_cnt_ff == baud_ff);

  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i || !en || tick)
      baud_cnt_ff <= 8'h00;
    else
      baud_cnt_ff <= baud_cnt_ff + 8'h01;
  end

  // transmit buffer; a write while full replaces the pending char
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      tx_buf_ff <= `TXDATA_RESET;
    else if (wr_tx)
      tx_buf_ff <= wbyte;
  end

  assign load   = en && (tx_state_ff == TX_IDLE) && !tbe_ff;
  assign tx_end = tick && (tx_os_ff == OS_LAST) && (tx_state_ff == TX_STOP)
                  && !tx_stop_left_ff;

  // buffer empty flag; disabling the channel discards pending data
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i || !en)
      tbe_ff <= 1'b1;
    else if (wr_tx)
      tbe_ff <= 1'b0;
    else if (load)
      tbe_ff <= 1'b1;
  end

  // busy from load to the end of the last stop bit
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i || !en)
      busy_ff <= 1'b0;
    else if (load)
      busy_ff <= 1'b1;
    else if (tx_end)
      busy_ff <= 1'b0;
  end

  // end of transmission, set wins over a clearing write
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      done_ff <= 1'b0;
    else
      done_ff <= tx_end | (done_ff & !(wr_status & wbyte[`ST_TX_DONE]));
  end

  // transmit shifter, line idles high
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i || !en)
    begin
      tx_state_ff     <= TX_IDLE;
      tx_shift_ff     <= 8'h00;
      tx_bit_ff       <= 3'd0;
      tx_os_ff        <= '0;
      tx_par_ff       <= 1'b0;
      tx_stop_left_ff <= 1'b0;
      serial_out_ff   <= 1'b1;
    end
    else if (load)
    begin
      tx_state_ff   <= TX_START;
      tx_shift_ff   <= char_mask(tx_buf_ff, mode_ff.char_length_select);
      tx_par_ff     <= parity_of(char_mask(tx_buf_ff, mode_ff.char_length_select),
                                 mode_ff.parity_odd);
      tx_bit_ff     <= 3'd0;
      tx_os_ff      <= '0;
      serial_out_ff <= 1'b0;
    end
    else if (tick && tx_os_ff != OS_LAST)
      tx_os_ff <= tx_os_ff + 1'b1;
    else if (tick)
    begin
      tx_os_ff <= '0;
      unique case (tx_state_ff)
        TX_IDLE:
          serial_out_ff <= 1'b1;
        TX_START:
        begin
          tx_state_ff   <= TX_DATA;
          serial_out_ff <= tx_shift_ff[0];
        end
        TX_DATA:
        begin
          if (tx_bit_ff == last_bit)
          begin
            tx_state_ff     <= mode_ff.parity_enable ? TX_PARITY : TX_STOP;
            serial_out_ff   <= mode_ff.parity_enable ? tx_par_ff : 1'b1;
            tx_stop_left_ff <= mode_ff.two_stop_bits;
          end
          else
          begin
            tx_bit_ff     <= tx_bit_ff + 3'd1;
            tx_shift_ff   <= {1'b0, tx_shift_ff[7:1]};
            serial_out_ff <= tx_shift_ff[1];
          end
        end
        TX_PARITY:
        begin
          tx_state_ff   <= TX_STOP;
          serial_out_ff <= 1'b1;
        end
        TX_STOP:
        begin
          if (tx_stop_left_ff)
            tx_stop_left_ff <= 1'b0;
          else
            tx_state_ff <= TX_IDLE;
        end
      endcase
    end
  end

  // two-flop synchroniser; receiver reads only the second
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      sin_meta_ff <= 1'b1;
      sin_sync_ff <= 1'b1;
    end
    else
    begin
      sin_meta_ff <= serial_in_pin_i;
      sin_sync_ff <= sin_meta_ff;
    end
  end

  // receiver; start bit rechecked at its middle to reject glitches
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i || !en)
    begin
      rx_state_ff   <= RX_IDLE;
      rx_shift_ff   <= 8'h00;
      rx_bit_ff     <= 3'd0;
      rx_os_ff      <= '0;
      rx_par_bit_ff <= 1'b0;
    end
    else if (tick)
    begin
      unique case (rx_state_ff)
        RX_IDLE:
        begin
          rx_os_ff <= '0;
          if (!sin_sync_ff)
            rx_state_ff <= RX_START;
        end
        RX_START:
        begin
          if (rx_os_ff == OS_MID)
          begin
            rx_os_ff    <= '0;
            rx_bit_ff   <= 3'd0;
            rx_shift_ff <= 8'h00;
            rx_state_ff <= sin_sync_ff ? RX_IDLE : RX_DATA;
          end
          else
            rx_os_ff <= rx_os_ff + 1'b1;
        end
        RX_DATA:
        begin
          rx_os_ff <= rx_os_ff + 1'b1;
          if (rx_os_ff == OS_LAST)
          begin
            rx_os_ff               <= '0;
            rx_shift_ff[rx_bit_ff] <= sin_sync_ff;
            rx_bit_ff              <= rx_bit_ff + 3'd1;
            if (rx_bit_ff == last_bit)
              rx_state_ff <= mode_ff.parity_enable ? RX_PARITY : RX_STOP;
          end
        end
        RX_PARITY:
        begin
          rx_os_ff <= rx_os_ff + 1'b1;
          if (rx_os_ff == OS_LAST)
          begin
            rx_os_ff      <= '0;
            rx_par_bit_ff <= sin_sync_ff;
            rx_state_ff   <= RX_STOP;
          end
        end
        RX_STOP:
        begin
          rx_os_ff <= rx_os_ff + 1'b1;
          if (rx_os_ff == OS_LAST)
          begin
            rx_os_ff    <= '0;
            rx_state_ff <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // char complete mid first stop bit
  assign rx_done     = tick && (rx_state_ff == RX_STOP) && (rx_os_ff == OS_LAST);
  assign push        = rx_done && ((count_ff != 2'd2) || pop);
  assign overrun_set = rx_done && (count_ff == 2'd2) && !pop;
  assign framing_set = rx_done && !sin_sync_ff;
  assign parity_set  = push && mode_ff.parity_enable
                       && (parity_of(rx_shift_ff, mode_ff.parity_odd) != rx_par_bit_ff);

  // receive fifo storage; an overrun char never reaches it
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      fifo_mem_ff[0] <= `RXDATA_RESET;
      fifo_mem_ff[1] <= `RXDATA_RESET;
    end
    else if (push)
      fifo_mem_ff[wr_ptr_ff] <= rx_shift_ff;
  end

  // fifo pointers and fill count
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff  <= 2'd0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= !wr_ptr_ff;
      if (pop)
        rd_ptr_ff <= !rd_ptr_ff;
      if (push && !pop)
        count_ff <= count_ff + 2'd1;
      else if (pop && !push)
        count_ff <= count_ff - 2'd1;
    end
  end

  // receive error flags, an event in the clearing cycle survives
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      framing_ff <= 1'b0;
      parity_ff  <= 1'b0;
      overrun_ff <= 1'b0;
    end
    else
    begin
      framing_ff <= framing_set | (framing_ff & !(wr_status & wbyte[`ST_FRAMING]));
      parity_ff  <= parity_set  | (parity_ff  & !(wr_status & wbyte[`ST_PARITY]));
      overrun_ff <= overrun_set | (overrun_ff & !(wr_status & wbyte[`ST_OVERRUN]));
    end
  end

  // enabled causes share one request line
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
      irq_ff <= 1'b0;
    else
      irq_ff <= (ctrl_ff.tx_empty_ie && tbe_ff)
              | (ctrl_ff.tx_end_ie && done_ff)
              | (ctrl_ff.rx_full_ie && (ctrl_ff.rx_threshold_select
                   ? (count_ff == 2'd2) : (count_ff != 2'd0)))
              | (ctrl_ff.rx_error_ie && (framing_ff | parity_ff | overrun_ff));
  end

  assign hreadyout_o      = hreadyout_ff;
  assign hrdata_o         = hrdata_ff;
  assign hresp_o          = hresp_ff;
  assign serial_out_pin_o = serial_out_ff;
  assign irq_o            = irq_ff;

endmodule

/* uart_data_status_regs_properties.sv */
`timescale 1ns/1ps
`include "uart_map.svh"

module uart_data_status_regs_properties
(
  input wire logic        ref_clk_i,        // clock
  input wire logic        reset_n_i,        // reset
  input wire logic        hsel_i,           // select
  input wire logic [31:0] haddr_i,          // address
  input wire logic [1:0]  htrans_i,         // transfer
  input wire logic        hwrite_i,         // write
  input wire logic [2:0]  hsize_i,          // size
  input wire logic [31:0] hwdata_i,         // wdata
  input wire logic        hready_i,         // ready in
  input wire logic        hreadyout_o,      // ready out
  input wire logic [31:0] hrdata_o,         // rdata
  input wire logic        hresp_o,          // response
  input wire logic        serial_in_pin_i,  // line in
  input wire logic        serial_out_pin_o, // line out
  input wire logic        irq_o             // request
);
  logic        rd_st_ff;  // status read in data phase
  logic        rd_tx_ff;  // tx data read in data phase
  logic        wr_tx_ff;  // tx data write in data phase
  logic        wr_ct_ff;  // control write in data phase
  logic        fresh_ff;  // nothing written since reset
  logic        tx_ok_ff;  // tx shadow trusted
  logic        ie_ff;     // an enable was ever set
  logic        en_ff;     // channel enable shadow
  logic [7:0]  txd_ff;    // tx data shadow
  logic        take;
  logic [15:0] idx;

  // index of the address phase
  assign take = hsel_i && htrans_i[1] && hready_i;
  assign idx  = haddr_i[17:2];

  // decode carried into the data phase
  always_ff @(posedge ref_clk_i)
  begin
    rd_st_ff <= take && !hwrite_i && idx == `IDX_STATUS;
    rd_tx_ff <= take && !hwrite_i && idx == `IDX_TXDATA;
    wr_tx_ff <= take && hwrite_i && idx == `IDX_TXDATA;
    wr_ct_ff <= take && hwrite_i && idx == `IDX_CTRL;
  end

  // shadows; tx trust ends at a control write
  always_ff @(posedge ref_clk_i)
  begin
    if (!reset_n_i)
    begin
      fresh_ff <= 1'b1;
      tx_ok_ff <= 1'b1;
      ie_ff    <= 1'b0;
      en_ff    <= 1'b0;
      txd_ff   <= `TXDATA_RESET;
    end
    else
    begin
      if (take && hwrite_i)
        fresh_ff <= 1'b0;
      if (wr_tx_ff)
        txd_ff <= hwdata_i[7:0];
      tx_ok_ff <= (tx_ok_ff || wr_tx_ff) && !wr_ct_ff;
      if (wr_ct_ff)
      begin
        en_ff <= hwdata_i[0];
        ie_ff <= ie_ff || hwdata_i[7:4] != 4'h0;
      end
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence s_off2;
    !en_ff [*2];
  endsequence

  property p_bus_ok;
    hreadyout_o && !hresp_o;
  endproperty
  a_bus_ok: assert property (p_bus_ok) else $error("bus not ready or not okay");

  property p_reset_out;
    $rose(reset_n_i) |-> serial_out_pin_o && !irq_o && hrdata_o == 32'h0000_0000;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs off after reset");

  property p_upper_zero;
    hrdata_o[31:8] == 24'h00_0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");

  property p_fresh_status;
    rd_st_ff && fresh_ff |-> hrdata_o[7:0] == `STATUS_RESET;
  endproperty
  a_fresh_status: assert property (p_fresh_status) else $error("status reset image");

  property p_pair;
    rd_st_ff && hrdata_o[3] |-> hrdata_o[1];
  endproperty
  a_pair: assert property (p_pair) else $error("second byte without ready");

  property p_txd_back;
    rd_tx_ff && tx_ok_ff |-> hrdata_o[7:0] == txd_ff;
  endproperty
  a_txd_back: assert property (p_txd_back) else $error("tx data readback");

  property p_quiet_irq;
    !ie_ff |-> !irq_o;
  endproperty
  a_quiet_irq: assert property (p_quiet_irq) else $error("request with no enable");

  property p_idle_line;
    s_off2 |-> serial_out_pin_o;
  endproperty
  a_idle_line: assert property (p_idle_line) else $error("line low while off");

  property p_rdata_stands;
    !(take && !hwrite_i) |=> $stable(hrdata_o);
  endproperty
  a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
endmodule

bind uart_data_status_regs uart_data_status_regs_properties i_props
(
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hrdata_o(hrdata_o), .hresp_o(hresp_o),
  .serial_in_pin_i(serial_in_pin_i), .serial_out_pin_o(serial_out_pin_o), .irq_o(irq_o)
);

/* uart_remote.sv */
`timescale 1ns/1ps

module uart_remote
#(
  parameter int BIT_CYC = 8
)
(
  input  wire logic ref_clk_i,  // system clock
  input  wire logic line_in_i,  // device line out
  output logic      line_out_o  // device line in
);
  int         nbits = 7;   // data bits per char
  bit         par_on = 0;  // parity bit in frame
  logic [7:0] got_q[$];    // chars heard

  initial line_out_o = 1'b1;

  // one full bit time
  task automatic hold(input logic v);
    line_out_o <= v;
    repeat (BIT_CYC) @(posedge ref_clk_i);
  endtask

  // one frame, lsb first, even parity; flags spoil parity or stop
  task automatic send(input logic [7:0] d, input bit bad_par, input bit bad_stop);
    @(posedge ref_clk_i);
    hold(1'b0);
    for (int i = 0; i < nbits; i++)
      hold(d[i]);
    if (par_on)
      hold(^d ^ bad_par);
    hold(!bad_stop);
    hold(1'b1);  // idle gap keeps the next start edge clean
  endtask

  // listener samples each bit near its middle
  initial
  begin
    logic [7:0] c;
    forever
    begin
      @(negedge line_in_i);
      c = 8'h00;
      repeat (BIT_CYC / 2) @(posedge ref_clk_i);
      for (int i = 0; i < nbits; i++)
      begin
        repeat (BIT_CYC) @(posedge ref_clk_i);
        c[i] = line_in_i;
      end
      repeat (par_on ? 2 * BIT_CYC : BIT_CYC) @(posedge ref_clk_i);
      got_q.push_back(c);
    end
  end
endmodule

/* uart_data_status_regs_bench.sv */
`timescale 1ns/1ps
`include "uart_map.svh"

module uart_data_status_regs_bench;
  localparam int BIT = 8;  // baud stays zero: a bit is OVERSAMPLE cycles

  logic        ref_clk;
  logic        reset_n;
  logic        hsel;
  logic        hwrite;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic        sin;
  logic        sout;
  logic        irq;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  int          err_total = 0;
  int          comparisons = 0;

  assign hready = hreadyout;

  uart_data_status_regs #(.OVERSAMPLE(BIT)) i_dut
  (
    .ref_clk_i(ref_clk), .reset_n_i(reset_n), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hreadyout), .hrdata_o(hrdata), .hresp_o(hresp),
    .serial_in_pin_i(sin), .serial_out_pin_o(sout), .irq_o(irq)
  );

  uart_remote #(.BIT_CYC(BIT)) i_far
  (
    .ref_clk_i(ref_clk), .line_in_i(sout), .line_out_o(sin)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one word transfer; only the watchdog bounds the waits
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {14'h0, idx, 2'b00};
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [7:0] exp);
    xfer(1'b0, idx, 8'h00);
    check(rd[7:0], exp);
  endtask

  // watchdog: whole run needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end

  initial
  begin
    reset_n = 1'b0;
    hsel    = 1'b0;
    htrans  = 2'b00;
    haddr   = 32'h0000_0000;
    hwrite  = 1'b0;
    hwdata  = 32'h0000_0000;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    // reset image, read-only places, unmapped slot
    rchk(`IDX_STATUS, `STATUS_RESET);
    rchk(`IDX_RXDATA, `RXDATA_RESET);
    rchk(`IDX_TXDATA, `TXDATA_RESET);
    rchk(16'h4105, 8'h00);
    wr(`IDX_RXDATA, 8'h55);
    wr(`IDX_STATUS, 8'h0f);
    rchk(`IDX_RXDATA, 8'h00);
    rchk(`IDX_STATUS, 8'h01);
    // two chars back to back, seven-bit format
    wr(`IDX_CTRL, 8'h81);
    wr(`IDX_TXDATA, 8'hc5);
    rchk(`IDX_TXDATA, 8'hc5);
    rchk(`IDX_STATUS, 8'h05);
    wr(`IDX_TXDATA, 8'h3a);
    rchk(`IDX_STATUS, 8'h04);
    check({7'h0, irq}, 8'h00);
    wait (i_far.got_q.size() == 2);
    repeat (2 * BIT + 1) @(posedge ref_clk);
    check(i_far.got_q[0], 8'h45);
    check(i_far.got_q[1], 8'h3a);
    rchk(`IDX_STATUS, 8'h81);
    check({7'h0, irq}, 8'h01);
    wr(`IDX_STATUS, 8'h00);
    rchk(`IDX_STATUS, 8'h81);
    wr(`IDX_STATUS, 8'h80);
    rchk(`IDX_STATUS, 8'h01);
    check({7'h0, irq}, 8'h00);
    // receive: eight bits, even parity, two-char threshold
    wr(`IDX_CTRL, 8'h10);
    wr(`IDX_MODE, 8'h18);
    check({7'h0, irq}, 8'h01);
    wr(`IDX_CTRL, 8'h23);
    i_far.nbits = 8;
    i_far.par_on = 1'b1;
    i_far.send(8'ha1, 1'b0, 1'b0);
    rchk(`IDX_STATUS, 8'h03);
    check({7'h0, irq}, 8'h00);
    i_far.send(8'h5e, 1'b0, 1'b0);
    rchk(`IDX_STATUS, 8'h0b);
    check({7'h0, irq}, 8'h01);
    i_far.send(8'h77, 1'b0, 1'b0);
    rchk(`IDX_STATUS, 8'h1b);
    rchk(`IDX_RXDATA, 8'ha1);
    rchk(`IDX_STATUS, 8'h13);
    rchk(`IDX_RXDATA, 8'h5e);
    rchk(`IDX_STATUS, 8'h11);
    xfer(1'b0, `IDX_RXDATA, 8'h00);
    rchk(`IDX_STATUS, 8'h11);
    wr(`IDX_STATUS, 8'h00);
    rchk(`IDX_STATUS, 8'h11);
    wr(`IDX_STATUS, 8'h10);
    rchk(`IDX_STATUS, 8'h01);
    // spoiled parity, then spoiled stop bit
    i_far.send(8'h3c, 1'b1, 1'b0);
    rchk(`IDX_STATUS, 8'h23);
    i_far.send(8'h8f, 1'b0, 1'b1);
    rchk(`IDX_STATUS, 8'h6b);
    wr(`IDX_STATUS, 8'h60);
    rchk(`IDX_RXDATA, 8'h3c);
    rchk(`IDX_RXDATA, 8'h8f);
    rchk(`IDX_STATUS, 8'h01);
    // seven-bit receive, top bit zero
    wr(`IDX_CTRL, 8'h00);
    wr(`IDX_MODE, 8'h00);
    wr(`IDX_CTRL, 8'h21);
    i_far.nbits = 7;
    i_far.par_on = 1'b0;
    i_far.send(8'hff, 1'b0, 1'b0);
    check({7'h0, irq}, 8'h01);
    rchk(`IDX_RXDATA, 8'h7f);
    tally_and_finish();
  end
endmodule
